// ---- rtl/mapl_top.sv ----
// madi and aes port logic with avalon-mm register slave
// ***************************************************
// How it works
// (RULE1) quad range drives aes at true 128, 176.4 or 192 kHz rate
// (RULE2) quad range keeps madi frames at 48 kHz, four-way multiplexed
// (RULE3) quad range carries at most 16 channels per madi port
// (RULE4) redundancy on: failed active input switches to the other at once
// (RULE5) switch-over completes well within one sample period
// (RULE6) mirror on: outputs 2 and 3 repeat output 1 exactly
// (RULE7) received aes channel status is dropped, changes nothing
// (RULE8) sent channel status carries sample rate up to 192 kHz
// (RULE9) audio, copy permitted, general, no generation, 2-channel, no emphasis
// (RULE10) sent status is professional or consumer by user setting
// (RULE11) sent status marks aux bits as audio, word length 24 bits
// (RULE12) three midi byte streams each way travel inside madi
// (RULE13) double range carries at most 32 channels per madi port
// (RULE14) each madi port selects 56 or 64 channel format
// (RULE15) pro setting on gives professional, off gives consumer
// (RULE16) input fails on lock loss or bad stream; no switch back otherwise
// (RULE17) unspecified status bits zero, block rebuilt same each block
// ***************************************************
`timescale 1ns/1ps
module mapl_top
   import mapl_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic [5:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   input  wire logic              rxa_lock,
   input  wire logic              rxa_ok,
   input  wire logic              rxb_lock,
   input  wire logic              rxb_ok,
   input  wire logic [23:0]       rxa_word,
   input  wire logic              rxa_stb,
   input  wire logic [23:0]       rxb_word,
   input  wire logic              rxb_stb,
   output logic [23:0]            rx_word,
   output logic                   rx_stb,
   output logic                   rx_sel,
   input  wire logic [2:0]        tx_enc,
   output logic [2:0]             tx_out,
   output logic [2:0]             port_frame96,
   output logic [5:0]             port_smux,
   output logic [20:0]            port_chans,
   output logic [3:0]             aes_rate,
   input  wire logic              aes_frame_stb,
   output logic                   aes_cs_bit,
   output logic                   aes_blk_start,
   output logic                   midi_tx_valid,
   input  wire logic              midi_tx_ready,
   output mapl_pkg::mapl_midi_t   midi_tx,
   input  wire logic              midi_rx_valid,
   input  wire mapl_pkg::mapl_midi_t midi_rx
);
   logic [1:0]            rst_q;
   logic                  rst_n;
   mapl_ctrl_t            ctrl_q;
   mapl_range_t           range;
   logic [1:0]            sa_q;
   logic [1:0]            sa2_q;
   logic [1:0]            sb_q;
   logic [1:0]            sb2_q;
   logic                  a_good;
   logic                  b_good;
   logic                  rd_pend_q;
   logic                  rd_take;
   logic                  tx_sel;
   logic                  tx_ready;
   logic                  tx_full;
   logic [31:0]           rdata_d;
   logic [NMIDI-1:0]      mrx_flag_q;
   logic [7:0]            mrx_byte_q [NMIDI];
   logic [CS_BITS-1:0]    cs_d;
   logic [CS_BITS-1:0]    cs_q;
   logic [7:0]            cs_cnt_q;
   logic [3:0]            rate_i;

   // ***************************************************
   // reset release and pin synchronisers
   // ***************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sa_q  <= 2'b00;
         sa2_q <= 2'b00;
         sb_q  <= 2'b00;
         sb2_q <= 2'b00;
      end
      else
      begin
         sa_q  <= {rxa_lock, rxa_ok};
         sa2_q <= sa_q;
         sb_q  <= {rxb_lock, rxb_ok};
         sb2_q <= sb_q;
      end
   end
   assign a_good = &sa2_q; // see RULE16
   assign b_good = &sb2_q; // see RULE16

   // ***************************************************
   // avalon-mm slave
   // ***************************************************
   // reads take one wait cycle so read data comes from a flop
   assign tx_sel  = avs_write && (avs_address == REG_MIDI_TX);
   assign rd_take = avs_read && rd_pend_q;
   assign avs_waitrequest = (avs_read && !rd_pend_q) || (tx_sel && !tx_ready);

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
         REG_CTRL:    rdata_d = ctrl_q;
         REG_STATUS:  rdata_d = {26'h0, range, tx_full, b_good, a_good, rx_sel};
         REG_MIDI_RX: rdata_d = {23'h0, mrx_flag_q[0], mrx_byte_q[0]};
         6'h10:       rdata_d = {23'h0, mrx_flag_q[1], mrx_byte_q[1]};
         6'h14:       rdata_d = {23'h0, mrx_flag_q[2], mrx_byte_q[2]};
         default:     rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_pend_q    <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         rd_pend_q <= avs_read && !rd_pend_q;
         if (avs_read && !rd_pend_q)
            avs_readdata <= rdata_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_q <= CTRL_RESET;
      else if (avs_write && avs_address == REG_CTRL)
         ctrl_q <= {19'h0, avs_writedata[12:0]};
   end

   // ***************************************************
   // rate range and per-port madi format
   // ***************************************************
   assign rate_i = (ctrl_q.rate > RATE_MAX) ? RATE_MAX : ctrl_q.rate;
   assign range  = (rate_i >= RATE_QUAD_MIN) ? RANGE_QUAD :
                   (rate_i >= RATE_DOUBLE_MIN) ? RANGE_DOUBLE : RANGE_SS;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         aes_rate <= 4'h0;
      else
         aes_rate <= rate_i; // undivided rate, see RULE1
   end

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++)
      begin : g_port
         logic [6:0] base;
         assign base = ctrl_q.fmt64[gp] ? CH64 : CH56; // see RULE14
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               port_frame96[gp]     <= 1'b0;
               port_smux[2*gp+:2]   <= SMUX1;
               port_chans[7*gp+:7]  <= CH56;
            end
            else
            begin
               unique case (range)
                  RANGE_SS:
                  begin
                     port_frame96[gp]    <= 1'b0;
                     port_smux[2*gp+:2]  <= SMUX1;
                     port_chans[7*gp+:7] <= base;
                  end
                  RANGE_DOUBLE:
                  begin
                     // native 96k frame or 2-way smux at 48k, see RULE13
                     port_frame96[gp]    <= ctrl_q.frame96[gp];
                     port_smux[2*gp+:2]  <= ctrl_q.frame96[gp] ? SMUX1 : SMUX2;
                     port_chans[7*gp+:7] <= {1'b0, base[6:1]};
                  end
                  RANGE_QUAD:
                  begin
                     port_frame96[gp]    <= 1'b0;  // see RULE2
                     port_smux[2*gp+:2]  <= SMUX4; // see RULE2
                     port_chans[7*gp+:7] <= {2'b00, base[6:2]}; // see RULE3
                  end
               endcase
            end
         end
      end
   endgenerate

   // ***************************************************
   // redundant input selection
   // ***************************************************
   // switching needs only the synchroniser delay, a few cycles,
   // far below one sample period
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_sel <= 1'b0;
      else if (ctrl_q.redund)
      begin
         if (!rx_sel && !a_good && b_good)
            rx_sel <= 1'b1; // see RULE4
         else if (rx_sel && !b_good && a_good)
            rx_sel <= 1'b0; // see RULE16
      end
      else
         rx_sel <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_word <= 24'h00_0000;
         rx_stb  <= 1'b0;
      end
      else
      begin
         rx_word <= rx_sel ? rxb_word : rxa_word; // see RULE5
         rx_stb  <= rx_sel ? rxb_stb : rxa_stb;
      end
   end

   // ***************************************************
   // output mirroring
   // ***************************************************
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_out <= 3'b000;
      else if (ctrl_q.mirror)
         tx_out <= {3{tx_enc[0]}}; // see RULE6
      else
         tx_out <= tx_enc;
   end

   // ***************************************************
   // aes channel status generator
   // ***************************************************
   // the aes receiver's status never enters this block, see RULE7
   always_comb
   begin
      cs_d = '0; // see RULE17
      if (ctrl_q.aes_pro) // see RULE15
      begin
         cs_d[CS_PRO]          = 1'b1; // see RULE10
         cs_d[CS_EMPH+:3]      = EMPH_NONE; // see RULE9
         cs_d[CS_PFS+:2]       = PRO_FS[rate_i]; // see RULE8
         cs_d[CS_MODE+:4]      = MODE_2CH;
         cs_d[CS_AUX+:3]       = AUX_24; // see RULE11
         cs_d[CS_PWLEN+:3]     = WLEN_24;
         cs_d[CS_PFSX+:4]      = PRO_FSX[rate_i];
      end
      else
      begin
         cs_d[CS_COPY]         = 1'b1; // see RULE9
         cs_d[CS_CFS+:4]       = CON_FS[rate_i]; // see RULE8
         cs_d[CS_CMAX24]       = 1'b1; // see RULE11
         cs_d[CS_CWLEN+:3]     = WLEN_24;
      end
   end

   // status is captured once per block so a setting change never
   // tears a block in half
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_cnt_q      <= 8'h00;
         cs_q          <= '0;
         aes_cs_bit    <= 1'b0;
         aes_blk_start <= 1'b0;
      end
      else if (aes_frame_stb)
      begin
         aes_blk_start <= (cs_cnt_q == 8'h00);
         aes_cs_bit    <= (cs_cnt_q == 8'h00) ? cs_d[0] : cs_q[cs_cnt_q];
         if (cs_cnt_q == 8'h00)
            cs_q <= cs_d; // see RULE17
         cs_cnt_q <= (cs_cnt_q == 8'(CS_BITS - 1)) ? 8'h00 : cs_cnt_q + 8'h01;
      end
   end

   // ***************************************************
   // embedded midi streams
   // ***************************************************
   mapl_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_tx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (tx_sel),
      .in_ready  (tx_ready),
      .in_data   (avs_writedata[FIFO_W-1:0]),
      .out_valid (midi_tx_valid), // see RULE12
      .out_ready (midi_tx_ready),
      .out_data  (midi_tx),
      .full      (tx_full)
   );

   genvar gm;
   generate
      for (gm = 0; gm < NMIDI; gm++)
      begin : g_mrx
         logic hit;
         logic clr;
         assign hit = midi_rx_valid && (midi_rx.stream == 2'(gm));
         assign clr = rd_take && (avs_address == REG_MIDI_RX + 6'(4 * gm));
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               mrx_flag_q[gm] <= 1'b0;
               mrx_byte_q[gm] <= 8'h00;
            end
            else if (hit)
            begin
               mrx_flag_q[gm] <= 1'b1; // set wins, see RULE12
               mrx_byte_q[gm] <= midi_rx.data;
            end
            else if (clr)
               mrx_flag_q[gm] <= 1'b0;
         end
      end
   endgenerate

   // ***************************************************
   // checks
   // ***************************************************
   sequence s_a_fails;
      ctrl_q.redund && !rx_sel && !a_good && b_good;
   endsequence
   sequence s_to_b;
      ##1 rx_sel;
   endsequence

   chk_quad_rate: assert property (@(posedge clk) disable iff (!rst_n) // see RULE1
      ctrl_q.rate == 4'h8 |-> ##1 aes_rate == 4'h8)
      else $error("quad rate not driven undivided");
   chk_quad_smux: assert property (@(posedge clk) disable iff (!rst_n) // see RULE2
      range == RANGE_QUAD ##1 range == RANGE_QUAD
      |-> port_smux == {3{SMUX4}} && port_frame96 == 3'b000)
      else $error("quad range not smux4 at 48k");
   chk_quad_chans: assert property (@(posedge clk) disable iff (!rst_n) // see RULE3
      range == RANGE_QUAD |=> port_chans[6:0] <= 7'd16)
      else $error("quad range exceeds 16 channels");
   chk_double_chans: assert property (@(posedge clk) disable iff (!rst_n) // see RULE13
      range == RANGE_DOUBLE |=> port_chans[13:7] <= 7'd32)
      else $error("double range exceeds 32 channels");
   chk_fail_switch: assert property (@(posedge clk) disable iff (!rst_n) // see RULE4
      s_a_fails |-> s_to_b)
      else $error("no switch to second input");
   chk_switch_time: assert property (@(posedge clk) disable iff (!rst_n) // see RULE5
      ctrl_q.redund && !rx_sel && a_good && !(&sa_q) && b_good && (&sb_q) |-> ##[1:3] rx_sel)
      else $error("switch-over too slow");
   chk_no_backswitch: assert property (@(posedge clk) disable iff (!rst_n) // see RULE16
      rx_sel && b_good && ctrl_q.redund |=> rx_sel)
      else $error("switched back without failure");
   chk_mirror_copy: assert property (@(posedge clk) disable iff (!rst_n) // see RULE6
      ctrl_q.mirror |=> tx_out == {3{$past(tx_enc[0])}})
      else $error("mirrored outputs differ from port 1");
   chk_cs_pro: assert property (@(posedge clk) disable iff (!rst_n) // see RULE15
      aes_frame_stb && cs_cnt_q == 8'h00 |=> aes_blk_start && aes_cs_bit == $past(ctrl_q.aes_pro))
      else $error("status format bit wrong");
   chk_midi_rx: assert property (@(posedge clk) disable iff (!rst_n) // see RULE12
      midi_rx_valid && midi_rx.stream == 2'h1
      |=> mrx_flag_q[1] && mrx_byte_q[1] == $past(midi_rx.data))
      else $error("embedded midi byte lost");
endmodule

// ---- rtl/mapl_pkg.sv ----
// shared constants and types of the madi/aes port logic
package mapl_pkg;
   // ***************************************************
   // register map (byte addresses) and reset values
   // ***************************************************
   localparam logic [5:0] REG_CTRL    = 6'h00;
   localparam logic [5:0] REG_STATUS  = 6'h04;
   localparam logic [5:0] REG_MIDI_TX = 6'h08;
   localparam logic [5:0] REG_MIDI_RX = 6'h0C;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
   localparam int NPORT   = 3;
   localparam int NMIDI   = 3;
   localparam int FIFO_W  = 10;
   localparam int FIFO_D  = 16;
   // ***************************************************
   // sample rates: 32,44.1,48,64,88.2,96,128,176.4,192
   // ***************************************************
   localparam logic [3:0] RATE_DOUBLE_MIN = 4'h3;
   localparam logic [3:0] RATE_QUAD_MIN   = 4'h6;
   localparam logic [3:0] RATE_MAX        = 4'h8;
   typedef enum logic [1:0] {RANGE_SS, RANGE_DOUBLE, RANGE_QUAD} mapl_range_t;
   localparam logic [1:0] SMUX1 = 2'h0;
   localparam logic [1:0] SMUX2 = 2'h1;
   localparam logic [1:0] SMUX4 = 2'h2;
   localparam logic [6:0] CH56 = 7'h38;
   localparam logic [6:0] CH64 = 7'h40;
   // shortest sample period, 192 kHz, and clock period
   localparam int SAMPLE_NS = 5208;
   localparam int CLK_NS    = 4;
   localparam int SWITCH_MAX_CYC = SAMPLE_NS / CLK_NS;
   // ***************************************************
   // channel status layout, 192 bits per block
   // ***************************************************
   localparam int CS_BITS     = 192;
   localparam int CS_PRO      = 0;
   localparam int CS_COPY     = 2;
   localparam int CS_EMPH     = 2;
   localparam int CS_PFS      = 6;
   localparam int CS_MODE     = 8;
   localparam int CS_AUX      = 16;
   localparam int CS_PWLEN    = 19;
   localparam int CS_PFSX     = 35;
   localparam int CS_CFS      = 24;
   localparam int CS_CMAX24   = 32;
   localparam int CS_CWLEN    = 33;
   localparam logic [2:0] EMPH_NONE = 3'h1;
   localparam logic [3:0] MODE_2CH  = 4'h1;
   localparam logic [2:0] AUX_24    = 3'h1;
   localparam logic [2:0] WLEN_24   = 3'h5;
   localparam logic [1:0] PRO_FS [9] =
      '{2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
   localparam logic [3:0] PRO_FSX [9] =
      '{4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
   localparam logic [3:0] CON_FS [9] =
      '{4'h3, 4'h0, 4'h2, 4'hB, 4'h8, 4'hA, 4'h9, 4'hC, 4'hE};
   typedef struct packed {
      logic [18:0] unused;
      logic        aes_pro;
      logic        mirror;
      logic        redund;
      logic [2:0]  frame96;
      logic [2:0]  fmt64;
      logic [3:0]  rate;
   } mapl_ctrl_t;
   typedef struct packed {
      logic [1:0] stream;
      logic [7:0] data;
   } mapl_midi_t;
endpackage

// ---- rtl/mapl_fifo.sv ----
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module mapl_fifo #(
   parameter int W = 10,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic              full
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW:0]  wp_q;
   logic [AW:0]  rp_q;
   logic         push;
   logic         pop;
   assign full      = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign out_valid = (wp_q != rp_q);
   assign in_ready  = !full;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge clk)
   begin
      if (push)
         mem_q[wp_q[AW-1:0]] <= in_data;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
      end
   end
endmodule

// ---- sim/mapl_far_end.sv ----
// far-end model: two madi receivers, aes frame timing and a midi sink
`timescale 1ns/1ps
module mapl_far_end (
   input  wire logic        clk,
   input  wire logic        a_fail,
   input  wire logic        b_fail,
   input  wire logic        stall,
   output logic             rxa_lock,
   output logic             rxa_ok,
   output logic             rxb_lock,
   output logic             rxb_ok,
   output logic [23:0]      rxa_word,
   output logic             rxa_stb,
   output logic [23:0]      rxb_word,
   output logic             rxb_stb,
   output logic             aes_frame_stb,
   output logic             midi_tx_ready
);
   logic [1:0]  ph_q  = 2'h0;
   logic [15:0] cnt_q = 16'h0000;

   always_ff @(posedge clk)
   begin
      ph_q  <= ph_q + 2'h1;
      cnt_q <= cnt_q + 16'h0001;
   end

   // input a fails by losing lock, input b by a bad stream
   assign rxa_lock = ~a_fail;
   assign rxa_ok   = 1'b1;
   assign rxb_lock = 1'b1;
   assign rxb_ok   = ~b_fail;
   assign rxa_stb  = (ph_q == 2'h0);
   assign rxb_stb  = (ph_q == 2'h0);
   // words outside a strobe are inverted so a stale copy is caught
   assign rxa_word = rxa_stb ? {8'hA0, cnt_q} : ~{8'hA0, cnt_q};
   assign rxb_word = rxb_stb ? {8'hB0, cnt_q} : ~{8'hB0, cnt_q};
   assign aes_frame_stb = (ph_q == 2'h1);
   assign midi_tx_ready = ~stall;
endmodule

// ---- sim/tb_mapl_top.sv ----
// self-checking testbench of the madi and aes port logic
`timescale 1ns/1ps
module tb_mapl_top
   import mapl_pkg::*;
;
   logic clk = 1'b0, resetn = 1'b0;
   logic [5:0]  avs_address = 6'h00;
   logic        avs_read = 1'b0, avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rdv;
   logic        avs_waitrequest, rxa_lock, rxa_ok, rxb_lock, rxb_ok, rxa_stb, rxb_stb;
   logic [23:0] rxa_word, rxb_word, rx_word;
   logic        rx_stb, rx_sel, aes_frame_stb, aes_cs_bit, aes_blk_start;
   logic [2:0]  tx_enc = 3'h0, tx_out, port_frame96;
   logic [5:0]  port_smux;
   logic [20:0] port_chans;
   logic [3:0]  aes_rate;
   logic        midi_tx_valid, midi_tx_ready, midi_rx_valid = 1'b0;
   mapl_midi_t  midi_tx, midi_rx = '0;
   logic        a_fail = 1'b0, b_fail = 1'b0, stall = 1'b1;
   logic [191:0] cs1, cs2;
   int          miscompares = 0, n_tests = 0, cycles = 0, i, n;

   always #2 clk = ~clk;

   mapl_top mapl_top_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .rxa_lock(rxa_lock), .rxa_ok(rxa_ok), .rxb_lock(rxb_lock), .rxb_ok(rxb_ok),
      .rxa_word(rxa_word), .rxa_stb(rxa_stb), .rxb_word(rxb_word), .rxb_stb(rxb_stb),
      .rx_word(rx_word), .rx_stb(rx_stb), .rx_sel(rx_sel), .tx_enc(tx_enc),
      .tx_out(tx_out), .port_frame96(port_frame96), .port_smux(port_smux),
      .port_chans(port_chans), .aes_rate(aes_rate), .aes_frame_stb(aes_frame_stb),
      .aes_cs_bit(aes_cs_bit), .aes_blk_start(aes_blk_start),
      .midi_tx_valid(midi_tx_valid), .midi_tx_ready(midi_tx_ready), .midi_tx(midi_tx),
      .midi_rx_valid(midi_rx_valid), .midi_rx(midi_rx));

   mapl_far_end mapl_far_end_inst (.clk(clk), .a_fail(a_fail), .b_fail(b_fail),
      .stall(stall), .rxa_lock(rxa_lock), .rxa_ok(rxa_ok), .rxb_lock(rxb_lock),
      .rxb_ok(rxb_ok), .rxa_word(rxa_word), .rxa_stb(rxa_stb), .rxb_word(rxb_word),
      .rxb_stb(rxb_stb), .aes_frame_stb(aes_frame_stb), .midi_tx_ready(midi_tx_ready));

   // ***************************************************
   // checking and closing
   // ***************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // the run should take about 5500 cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         summarize();
      end
   end

   // ***************************************************
   // bus and helper tasks
   // ***************************************************
   // one avalon transfer; an edge passes first so requests never merge
   task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= wd;
      @(posedge clk);
      while (avs_waitrequest)
         @(posedge clk);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic cfg(input logic [31:0] c, input logic [20:0] ch, input logic [5:0] sm,
                      input logic [2:0] f96, input logic [1:0] rg);
      bus(REG_CTRL, 1'b1, c, rdv);
      repeat (3) @(posedge clk);
      chk("port_chans", {11'h0, port_chans}, {11'h0, ch});
      chk("port_smux", {26'h0, port_smux}, {26'h0, sm});
      chk("port_frame96", {29'h0, port_frame96}, {29'h0, f96});
      chk("aes_rate", {28'h0, aes_rate}, {28'h0, c[3:0]});
      bus(REG_STATUS, 1'b0, 32'h0000_0000, rdv);
      chk("range", {30'h0, rdv[5:4]}, {30'h0, rg});
   endtask

   // one status block; each bit lasts one frame of four cycles
   task automatic cap(output logic [191:0] cs);
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (aes_blk_start !== 1'b1 && i < 2000);
      for (int k = 0; k < CS_BITS; k++)
      begin
         cs[k] = aes_cs_bit;
         repeat (4) @(posedge clk);
      end
   endtask

   task automatic wait_sel(input logic v);
      i = 0;
      while (rx_sel !== v && i < 8)
      begin
         @(posedge clk);
         i++;
      end
      chk("rx_sel", {31'h0, rx_sel}, {31'h0, v});
   endtask

   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      chk("port_chans_rst", {11'h0, port_chans}, {11'h0, {3{CH56}}});
      bus(REG_CTRL, 1'b0, 32'h0000_0000, rdv);
      chk("ctrl_rst", rdv, CTRL_RESET);
      bus(6'h3C, 1'b0, 32'h0000_0000, rdv);
      chk("unmapped", rdv, 32'h0000_0000);
      cfg(32'h0000_0022, {CH56, CH64, CH56}, {3{SMUX1}}, 3'h0, 2'h0);
      cfg(32'h0000_0085, {3{7'h1C}}, {SMUX2, SMUX2, SMUX1}, 3'h1, 2'h1);
      cfg(32'h0000_0078, {3{7'h10}}, {3{SMUX4}}, 3'h0, 2'h2);
      // redundancy: a loses lock, later b reports a bad stream
      bus(REG_CTRL, 1'b1, 32'h0000_0402, rdv);
      a_fail <= 1'b1;
      wait_sel(1'b1);
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (rx_stb !== 1'b1 && i < 8);
      chk("rx_word_src", {24'h0, rx_word[23:16]}, 32'h0000_00B0);
      a_fail <= 1'b0;
      repeat (10) @(posedge clk);
      chk("rx_sel_hold", {31'h0, rx_sel}, 32'h0000_0001);
      b_fail <= 1'b1;
      wait_sel(1'b0);
      b_fail <= 1'b0;
      // mirror on, then off
      bus(REG_CTRL, 1'b1, 32'h0000_0802, rdv);
      tx_enc <= 3'b001;
      repeat (3) @(posedge clk);
      chk("tx_mirror1", {29'h0, tx_out}, 32'h0000_0007);
      tx_enc <= 3'b110;
      repeat (3) @(posedge clk);
      chk("tx_mirror0", {29'h0, tx_out}, 32'h0000_0000);
      bus(REG_CTRL, 1'b1, 32'h0000_0002, rdv);
      tx_enc <= 3'b101;
      repeat (3) @(posedge clk);
      chk("tx_plain", {29'h0, tx_out}, 32'h0000_0005);
      // channel status, professional at 192 kHz, then consumer
      bus(REG_CTRL, 1'b1, 32'h0000_1008, rdv);
      cap(cs1);
      cap(cs1);
      cap(cs2);
      chk("cs_pro", {31'h0, cs1[CS_PRO]}, 32'h0000_0001);
      chk("cs_pro_fs", {30'h0, cs1[7:6]}, {30'h0, PRO_FS[8]});
      chk("cs_pro_fsx", {28'h0, cs1[CS_PFSX+:4]}, {28'h0, PRO_FSX[8]});
      chk("cs_pro_aux", {26'h0, cs1[21:16]}, {26'h0, WLEN_24, AUX_24});
      chk("cs_pro_use", {25'h0, cs1[CS_MODE+:4], cs1[CS_EMPH+:3]}, {25'h0, MODE_2CH, EMPH_NONE});
      chk("cs_tail", {31'h0, |cs1[191:40]}, 32'h0000_0000);
      chk("cs_repeat", {31'h0, cs1 !== cs2}, 32'h0000_0000);
      bus(REG_CTRL, 1'b1, 32'h0000_0008, rdv);
      cap(cs1);
      cap(cs1);
      chk("cs_con", {31'h0, cs1[CS_PRO]}, 32'h0000_0000);
      chk("cs_copy", {31'h0, cs1[CS_COPY]}, 32'h0000_0001);
      chk("cs_con_fs", {28'h0, cs1[CS_CFS+:4]}, {28'h0, CON_FS[8]});
      chk("cs_tail_con", {31'h0, |cs1[191:40]}, 32'h0000_0000);
      // midi out: fill the fifo while the far end stalls, then drain
      for (int k = 0; k < FIFO_D; k++)
         bus(REG_MIDI_TX, 1'b1, 32'((k % 3) * 256 + 64 + k), rdv);
      bus(REG_STATUS, 1'b0, 32'h0000_0000, rdv);
      chk("fifo_full", {31'h0, rdv[3]}, 32'h0000_0001);
      stall <= 1'b0;
      n = 0;
      i = 0;
      while (n < FIFO_D && i < 100)
      begin
         @(posedge clk);
         i++;
         if (midi_tx_valid === 1'b1 && midi_tx_ready === 1'b1)
         begin
            chk("midi_tx", {22'h0, midi_tx}, 32'((n % 3) * 256 + 64 + n));
            n++;
         end
      end
      chk("midi_tx_count", 32'(n), 32'(FIFO_D));
      // midi in: one byte on each stream, flag clears on read
      for (int s = 0; s < NMIDI; s++)
      begin
         @(posedge clk);
         midi_rx       <= '{stream: 2'(s), data: 8'(8'h50 + s)};
         midi_rx_valid <= 1'b1;
         @(posedge clk);
         midi_rx_valid <= 1'b0;
         bus(6'(REG_MIDI_RX + 4 * s), 1'b0, 32'h0000_0000, rdv);
         chk("midi_rx_new", rdv, 32'(9'h150 + s));
         bus(6'(REG_MIDI_RX + 4 * s), 1'b0, 32'h0000_0000, rdv);
         chk("midi_rx_old", rdv, 32'(8'h50 + s));
      end
      summarize();
   end
endmodule
